// *** hdl/adsc_pkg.sv ***
// Contract
// - Repeat-scan converts selected channels back to back.
// - Scan starts lowest selected channel, then ascends.
// - Clearing repeat-scan enable stops repeated conversions.
// - Results carry tag of converted channel.
// - Control holds repeat-scan, start field, channel select.
// - Power bit 21 set powers converter up.
// - Global sleep bit 1 powers converter down.
// - Start codes 010-111 use edge bit polarity.
// - Control write mid-conversion restarts; sets done only past early window.
// - Early write restarts with only the restart flag; later sets done.
package adsc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NUM_CH = 8;
   localparam int CH_W = 3;
   localparam int RES_W = 10;
   localparam int NUM_EV = 6;

   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_PWR = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h10;

   // Control register layout
   localparam int SEL_LSB = 0;
   localparam int DIV_LSB = 8;
   localparam int DIV_W = 8;
   localparam int BURST_BIT = 16;
   localparam int POWER_BIT = 21;
   localparam int START_LSB = 24;
   localparam int START_W = 3;
   localparam int EDGE_BIT = 27;
   localparam logic [DATA_W-1:0] CTRL_MASK = 32'h0f21_ffff;
   localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;

   // Result register layout
   localparam int RES_LSB = 6;
   localparam int TAG_LSB = 24;
   localparam int OVERRUN_BIT = 30;
   localparam int DONE_BIT = 31;

   // Power control register
   localparam int SLEEP_BIT = 1;

   // Interrupt status and mask layout
   localparam int IRQ_W = 3;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_OVERRUN = 1;
   localparam int IRQ_RESTART = 2;

   localparam logic [START_W-1:0] START_NONE = 3'h0;
   localparam logic [START_W-1:0] START_NOW = 3'h1;
   localparam logic [START_W-1:0] START_EV0 = 3'h2;

   // Conversion length and early-write window in converter clocks
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CONV_TICKS = 4'hb;
   localparam logic [CNT_W-1:0] EARLY_TICKS = 4'h3;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CONV = 3'b010,
      ST_OFF = 3'b100
   } adsc_state_e;
endpackage : adsc_pkg

// *** hdl/adsc_scan_control.sv ***
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module adsc_sync2 #(
   parameter int W = 1
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   // Two stages before any logic sees an outside level
   logic [W-1:0] meta;

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         meta <= '0;
         sync_o <= '0;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end
endmodule : adsc_sync2

module adsc_scan_control import adsc_pkg::*; (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wr_data_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   output logic [DATA_W-1:0] rd_data_o,
   input wire logic [NUM_EV-1:0] timer_event_signal_i,
   input wire logic [RES_W-1:0] conv_data_i,
   output logic [CH_W-1:0] conv_channel_o,
   output logic conv_sample_o,
   output logic converter_power_on_o,
   output logic irq_o
);

   // Lowest selected channel
   function automatic logic [CH_W-1:0] first_ch(input logic [NUM_CH-1:0] sel);
      logic [CH_W-1:0] r;
      r = '0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (sel[i]) begin
            r = CH_W'(i);
         end
      end
      return r;
   endfunction : first_ch

   // Next selected channel above cur, wrapping to the lowest
   function automatic logic [CH_W-1:0] next_sel_ch(input logic [NUM_CH-1:0] sel,
                                                   input logic [CH_W-1:0] cur);
      logic [CH_W-1:0] r;
      r = first_ch(sel);
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (sel[i] && (CH_W'(i) > cur)) begin
            r = CH_W'(i);
         end
      end
      return r;
   endfunction : next_sel_ch

   logic [DATA_W-1:0] converter_control_reg;
   logic [DATA_W-1:0] power_control_reg;
   logic [IRQ_W-1:0] int_stat;
   logic [IRQ_W-1:0] int_mask;
   logic [RES_W-1:0] res_data;
   logic [CH_W-1:0] result_channel_tag;
   logic res_done;
   logic res_overrun;
   logic start_pending;
   adsc_state_e state;
   adsc_state_e next_state;
   logic [CH_W-1:0] chan;
   logic [CH_W-1:0] next_chan;
   logic [CNT_W-1:0] tick_cnt;
   logic [CNT_W-1:0] next_tick_cnt;
   logic [DIV_W-1:0] div_cnt;
   logic [NUM_EV-1:0] ev_sync;
   logic [NUM_EV-1:0] ev_prev;
   logic [RES_W-1:0] data_sync;
   logic start_conv;
   logic finish_conv;
   logic late_write;
   logic early_write;

   // Register decode
   wire wr_ctrl = wr_en_i && (addr_i == OFF_CTRL);
   wire wr_pwr = wr_en_i && (addr_i == OFF_PWR);
   wire wr_mask = wr_en_i && (addr_i == OFF_INT_MASK);
   wire rd_result = rd_en_i && (addr_i == OFF_RESULT);
   wire rd_stat = rd_en_i && (addr_i == OFF_INT_STAT);

   // Control fields as currently held
   wire [NUM_CH-1:0] sel = converter_control_reg[SEL_LSB +: NUM_CH];
   wire [DIV_W-1:0] conversion_clock_divider = converter_control_reg[DIV_LSB +: DIV_W];
   wire burst = converter_control_reg[BURST_BIT];
   wire [START_W-1:0] start_code = converter_control_reg[START_LSB +: START_W];
   wire edge_fall = converter_control_reg[EDGE_BIT];

   // Control fields of the value being written
   wire [NUM_CH-1:0] w_sel = wr_data_i[SEL_LSB +: NUM_CH];
   wire w_burst = wr_data_i[BURST_BIT];
   wire w_power = wr_data_i[POWER_BIT];
   wire [START_W-1:0] w_start = wr_data_i[START_LSB +: START_W];
   wire w_request = w_power && (w_sel != '0) && (w_burst || (w_start == START_NOW));

   // Sleep overrides the power bit, so the converter cannot stay up in sleep
   wire global_sleep = power_control_reg[SLEEP_BIT];
   wire active = converter_control_reg[POWER_BIT] && !global_sleep;

   // Converter clock enable from the divider
   wire conv_tick = active && (div_cnt == conversion_clock_divider);

   // Edge trigger on the selected timer event
   wire edge_code = (start_code >= START_EV0);
   // Codes 0 and 1 would index past the event inputs; park them on input 0
   wire [START_W-1:0] ev_idx = edge_code ? start_code - START_EV0 : '0;
   wire ev_cur = ev_sync[ev_idx];
   wire ev_old = ev_prev[ev_idx];
   wire edge_hit = edge_code && (edge_fall ? (ev_old && !ev_cur) : (!ev_old && ev_cur));

   wire idle_request = (sel != '0) && (burst || start_pending || edge_hit);
   wire last_tick = conv_tick && (tick_cnt == CONV_TICKS - 4'h1);
   wire [DATA_W-1:0] result_word = {res_done, res_overrun, 3'h0, result_channel_tag,
                                    8'h00, res_data, 6'h00};
   wire [IRQ_W-1:0] irq_events = {late_write || early_write,
                                  finish_conv && res_done,
                                  finish_conv || late_write};
   wire [DATA_W-1:0] rd_mux =
      (addr_i == OFF_CTRL) ? converter_control_reg :
      (addr_i == OFF_RESULT) ? result_word :
      (addr_i == OFF_PWR) ? power_control_reg :
      (addr_i == OFF_INT_STAT) ? {29'h0, int_stat} :
      (addr_i == OFF_INT_MASK) ? {29'h0, int_mask} : 32'h0000_0000;

   always_comb begin
      next_state = state;
      next_chan = chan;
      next_tick_cnt = tick_cnt;
      start_conv = 1'b0;
      finish_conv = 1'b0;
      late_write = 1'b0;
      early_write = 1'b0;
      case (state)
         ST_OFF: begin
            if (active) begin
               next_state = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (!active) begin
               next_state = ST_OFF;
            end else if (idle_request && !wr_ctrl) begin
               next_state = ST_CONV;
               next_chan = first_ch(sel);
               next_tick_cnt = '0;
               start_conv = 1'b1;
            end
         end
         ST_CONV: begin
            if (!active) begin
               next_state = ST_OFF;
            end else if (wr_ctrl) begin
               // Early write restarts without done, later one flags done
               early_write = (tick_cnt < EARLY_TICKS);
               late_write = !early_write;
               next_tick_cnt = '0;
               if (w_request) begin
                  next_chan = first_ch(w_sel);
                  start_conv = 1'b1;
               end else begin
                  next_state = ST_IDLE;
               end
            end else if (conv_tick) begin
               next_tick_cnt = tick_cnt + 4'h1;
               if (last_tick) begin
                  finish_conv = 1'b1;
                  next_tick_cnt = '0;
                  if (burst && (sel != '0)) begin
                     next_chan = next_sel_ch(sel, chan);
                     start_conv = 1'b1;
                  end else begin
                     next_state = ST_IDLE;
                  end
               end
            end
         end
         default: begin
            next_state = ST_OFF;
         end
      endcase
   end

   // Synchronisers for the outside inputs
   adsc_sync2 #(
      .W(NUM_EV)
   ) u_ev_sync (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .async_i(timer_event_signal_i),
      .sync_o(ev_sync)
   );

   adsc_sync2 #(
      .W(RES_W)
   ) u_data_sync (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .async_i(conv_data_i),
      .sync_o(data_sync)
   );

   // Edge history, one cycle behind the synchronised level
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         ev_prev <= '0;
      end else begin
         ev_prev <= ev_sync;
      end
   end

   // Control and power registers; unused bits read as zero
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         converter_control_reg <= CTRL_RESET;
      end else if (wr_ctrl) begin
         converter_control_reg <= wr_data_i & CTRL_MASK;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         power_control_reg <= '0;
      end else if (wr_pwr) begin
         power_control_reg <= {30'h0, wr_data_i[SLEEP_BIT], 1'b0};
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         int_mask <= '0;
      end else if (wr_mask) begin
         int_mask <= wr_data_i[IRQ_W-1:0];
      end
   end

   // Scan sequencer
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         state <= ST_OFF;
         chan <= '0;
         tick_cnt <= '0;
      end else begin
         state <= next_state;
         chan <= next_chan;
         tick_cnt <= next_tick_cnt;
      end
   end

   // Converter clock divider, held at zero while powered down
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= (conv_tick || !active) ? '0 : div_cnt + 8'h01;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         start_pending <= 1'b0;
      end else if (wr_ctrl) begin
         start_pending <= (w_start == START_NOW) && (state != ST_CONV);
      end else if (start_conv || !active) begin
         start_pending <= 1'b0;
      end
   end

   // Result data and channel tag
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         res_data <= '0;
         result_channel_tag <= '0;
      end else if (finish_conv) begin
         res_data <= data_sync;
         result_channel_tag <= chan;
      end
   end

   // Result flags; a new completion wins over a clearing read
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         res_done <= 1'b0;
         res_overrun <= 1'b0;
      end else begin
         if (finish_conv || late_write) begin
            res_done <= 1'b1;
            res_overrun <= finish_conv && res_done;
         end else if (rd_result) begin
            res_done <= 1'b0;
            res_overrun <= 1'b0;
         end
      end
   end

   // Interrupts; an event in the cycle of the clearing read stays set
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         int_stat <= '0;
         irq_o <= 1'b0;
      end else begin
         int_stat <= irq_events | (rd_stat ? '0 : int_stat);
         irq_o <= |(int_stat & int_mask);
      end
   end

   // Bus read data stands for one cycle only
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         rd_data_o <= '0;
      end else begin
         rd_data_o <= rd_en_i ? rd_mux : '0;
      end
   end

   // Converter outputs
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         conv_channel_o <= '0;
         conv_sample_o <= 1'b0;
         converter_power_on_o <= 1'b0;
      end else begin
         conv_channel_o <= next_chan;
         conv_sample_o <= start_conv;
         converter_power_on_o <= active;
      end
   end

endmodule : adsc_scan_control

// *** tb/adsc_analog_model.sv ***
`timescale 1ns/10ps
module adsc_analog_model import adsc_pkg::*; (
   input wire logic sys_clk_i,
   input wire logic [CH_W-1:0] conv_channel_i,
   input wire logic converter_power_on_i,
   output logic [RES_W-1:0] conv_data_o
);
   initial conv_data_o = '0;
   // Level tracks the channel; unpowered front end has no stable level
   always @(posedge sys_clk_i) begin
      if (converter_power_on_i) conv_data_o <= {conv_channel_i, 7'h35};
      else conv_data_o <= ~conv_data_o;
   end
endmodule : adsc_analog_model

// *** tb/adsc_scan_control_props.sv ***
`timescale 1ns/10ps
module adsc_chk import adsc_pkg::*; (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wr_data_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [DATA_W-1:0] rd_data_o,
   input wire logic [CH_W-1:0] conv_channel_o,
   input wire logic conv_sample_o,
   input wire logic converter_power_on_o,
   input wire logic irq_o
);
   logic [DATA_W-1:0] ctrl_seen;
   logic [IRQ_W-1:0] mask_seen;
   wire logic ctrl_wr = wr_en_i && addr_i == OFF_CTRL;
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         ctrl_seen <= '0;
         mask_seen <= '0;
      end else begin
         if (ctrl_wr) ctrl_seen <= wr_data_i;
         if (wr_en_i && addr_i == OFF_INT_MASK) mask_seen <= wr_data_i[IRQ_W-1:0];
      end
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   property p_pwr_off;
      ctrl_wr && !wr_data_i[POWER_BIT] |-> ##[1:2] !converter_power_on_o;
   endproperty
   a_pwr_off: assert property (p_pwr_off) else $error("power stays on");
   property p_sleep;
      wr_en_i && addr_i == OFF_PWR && wr_data_i[SLEEP_BIT] |-> ##[1:2] !converter_power_on_o;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep ignored");
   property p_sel;
      conv_sample_o |-> ctrl_seen[SEL_LSB + int'(conv_channel_o)];
   endproperty
   a_sel: assert property (p_sel) else $error("unselected channel");
   property p_stop;
      ctrl_wr && !wr_data_i[BURST_BIT] && wr_data_i[START_LSB+:START_W] == START_NONE
         |=> (!conv_sample_o)[*8];
   endproperty
   a_stop: assert property (p_stop) else $error("scan kept running");
   property p_pwr_smp;
      conv_sample_o |-> $past(converter_power_on_o);
   endproperty
   a_pwr_smp: assert property (p_pwr_smp) else $error("sample while off");
   // A write may legally restart or stop the scan, so it waives the spacing
   property p_burst;
      conv_sample_o && ctrl_seen[BURST_BIT] && ctrl_seen[DIV_LSB+:DIV_W] == '0 && !wr_en_i
         |-> (##[10:12] conv_sample_o) or (##[1:12] wr_en_i);
   endproperty
   a_burst: assert property (p_burst) else $error("scan spacing");
   property p_irq_mask;
      mask_seen == '0 && $past(mask_seen) == '0 |-> !irq_o;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("masked irq");
   property p_rd_idle;
      !$past(rd_en_i) |-> rd_data_o == '0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule : adsc_chk
bind adsc_scan_control adsc_chk u_chk (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
   .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
   .rd_data_o(rd_data_o), .conv_channel_o(conv_channel_o), .conv_sample_o(conv_sample_o),
   .converter_power_on_o(converter_power_on_o), .irq_o(irq_o));

// *** tb/testbench.sv ***
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module testbench import adsc_pkg::*;;
   localparam logic [DATA_W-1:0] PW = 1 << POWER_BIT;
   localparam logic [DATA_W-1:0] BR = 1 << BURST_BIT;
   localparam logic [DATA_W-1:0] NOW = 1 << START_LSB;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [NUM_EV-1:0] ev = '0;
   logic [DATA_W-1:0] rd_data, r;
   logic [RES_W-1:0] cdata;
   logic [CH_W-1:0] chan;
   logic smp, pwr, irq;
   int n_mismatch = 0;
   int n_compared = 0;
   logic [ADDR_W-1:0] offs [6] = '{OFF_CTRL, OFF_RESULT, OFF_PWR, OFF_INT_STAT, OFF_INT_MASK, 8'h40};
   always #5 sys_clk = ~sys_clk;
   adsc_scan_control dut (.sys_clk_i(sys_clk), .rstn_i(rstn), .addr_i(addr), .wr_data_i(wdata),
      .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data), .timer_event_signal_i(ev),
      .conv_data_i(cdata), .conv_channel_o(chan), .conv_sample_o(smp),
      .converter_power_on_o(pwr), .irq_o(irq));
   adsc_analog_model u_model (.sys_clk_i(sys_clk), .conv_channel_i(chan),
      .converter_power_on_i(pwr), .conv_data_o(cdata));
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1;
      d = rd_data;
   endtask : rd
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : settle
   task automatic wait_done(input logic [CH_W-1:0] ch);
      logic [DATA_W-1:0] v;
      v = '0;
      for (int i = 0; i < 40 && v[DONE_BIT] !== 1'b1; i++) begin
         rd(OFF_RESULT, v);
      end
      `CHK("done", 1'b1, v[DONE_BIT])
      `CHK("tag", ch, v[TAG_LSB+:CH_W])
      `CHK("data", {ch, 7'h35}, v[RES_LSB+:RES_W])
   endtask : wait_done
   task automatic print_verdict();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   initial begin
      int c;
      int e;
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      wr(8'h40, '1);
      foreach (offs[i]) begin
         rd(offs[i], r);
         `CHK("reset", 32'h0, r)
      end
      wr(OFF_INT_MASK, 32'h7);
      wr(OFF_CTRL, PW | 32'h05);
      wr(OFF_CTRL, PW | BR | 32'h05);
      wait_done(3'h0);
      wait_done(3'h2);
      wait_done(3'h0);
      wr(OFF_CTRL, PW | 32'h05);
      settle(15);
      rd(OFF_RESULT, r);
      settle(20);
      rd(OFF_RESULT, r);
      `CHK("stopped", 1'b0, r[DONE_BIT])
      rd(OFF_INT_STAT, r);
      wr(OFF_INT_MASK, 32'h0);
      wr(OFF_CTRL, PW | NOW | 32'h08);
      settle(20);
      `CHK("masked", 1'b0, irq)
      wr(OFF_INT_MASK, 32'h1);
      settle(1);
      `CHK("irq", 1'b1, irq)
      wait_done(3'h3);
      rd(OFF_INT_STAT, r);
      `CHK("stat", 32'h1, r)
      settle(1);
      `CHK("irq", 1'b0, irq)
      // Deliberate writes mid-conversion, inside and past the early window
      wr(OFF_CTRL, PW | NOW | 32'h08);
      wr(OFF_CTRL, PW | NOW | 32'h08);
      rd(OFF_INT_STAT, r);
      `CHK("early", 32'h4, r)
      settle(3);
      wr(OFF_CTRL, PW | NOW | 32'h08);
      rd(OFF_INT_STAT, r);
      `CHK("late", 32'h5, r)
      rd(OFF_RESULT, r);
      wait_done(3'h3);
      rd(OFF_INT_STAT, r);
      wr(OFF_CTRL, PW | 32'h02);
      for (c = 2; c < 8; c++) begin
         for (e = 0; e < 2; e++) begin
            wr(OFF_CTRL, PW | 32'(c) << START_LSB | 32'(e) << EDGE_BIT | 32'h02);
            settle(10);
            rd(OFF_RESULT, r);
            `CHK("no start", 1'b0, r[DONE_BIT])
            @(posedge sys_clk);
            ev[c-2] <= ~ev[c-2];
            wait_done(3'h1);
         end
      end
      wr(OFF_CTRL, PW);
      settle(1);
      `CHK("power", 1'b1, pwr)
      wr(OFF_PWR, 32'h2);
      settle(1);
      `CHK("sleep", 1'b0, pwr)
      wr(OFF_PWR, 32'h0);
      wr(OFF_CTRL, '1);
      rd(OFF_CTRL, r);
      `CHK("ctrl", CTRL_MASK, r)
      wr(OFF_CTRL, 32'h0);
      settle(1);
      `CHK("off", 1'b0, pwr)
      wr(OFF_PWR, 32'h2);
      print_verdict();
   end
   // Whole sequence needs well under a thousand cycles
   initial begin
      #100us;
      n_mismatch++;
      print_verdict();
   end
endmodule : testbench
